// ==== rtl/lcrb_line_ctl.sv ====
// per-line loopback, duplex, break gating and line parameter registers
// Function
// - with the maintenance loop bit set each line's transmit serial feeds its own receiver.
// - with the maintenance loop bit clear each receiver is fed from the duplex control path.
// - in full duplex with the maintenance loop bit clear the incoming line data reaches the receiver at all times.
// - in half duplex with the maintenance loop bit clear a line whose transmitter is busy presents idle high to its receiver.
// - incoming line data is inverted once more before it reaches the receiver.
// - the loopback and duplex selection is repeated independently for all sixteen lines.
// - the parameter load strobe loads all sixteen parameter bits, and reads return them.
// - parameter bits 0 to 5 set character length, stop bits and parity of the selected line.
// - parameter bits 6 to 9 set the receive rate of the selected line.
// - parameter bits 10 to 13 set the transmit rate of the selected line.
// - parameter bits 14 and 15 set half duplex and auto echo of the selected line.
// - the active load strobe loads both bytes of the transmit-active register together.
// - each transmit-active bit is readable and drives the scanner's active flag for its line.
// - the break load strobe loads all sixteen break bits, and reads return them.
// - each transmit pin is the transmit serial data gated by the inverse of its break bit.
// - host address bits 1 to 3 select which register drives the read data.
`timescale 1ns/10ps
`include "lcrb_defs.svh"

module lcrb_line_ctl #(
  parameter int NUM_LINES = `LCRB_NUM_LINES
) (
  // clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // host register access
  input  wire lcrb_pkg::lcrb_word_t     host_data_buffered_i,
  input  wire logic                     param_load_strobe_i,
  input  wire logic                     active_load_strobe_i,
  input  wire logic                     brk_load_strobe_i,
  input  wire logic                     rd_en_i,
  input  wire logic [2:0]               rd_addr_i,
  output logic [15:0]                   rd_data_o,
  // system control inputs
  input  wire logic                     maintenance_loop_bit_i,
  input  wire lcrb_pkg::lcrb_line_t     line_sel_i,
  // selected line parameters
  output logic [5:0]                    char_format_o,
  output logic [3:0]                    rx_rate_o,
  output logic [3:0]                    tx_rate_o,
  output logic                          auto_echo_o,
  // transmitter scanner
  output logic [NUM_LINES-1:0]          line_active_o,
  // serial lines
  input  wire logic [NUM_LINES-1:0]     line_tx_serial_i,
  input  wire logic [NUM_LINES-1:0]     tx_char_done_i,
  input  wire logic [NUM_LINES-1:0]     line_rx_pin_i,
  output logic [NUM_LINES-1:0]          line_rx_serial_o,
  output logic [NUM_LINES-1:0]          line_tx_pin_o,
  output logic [NUM_LINES-1:0]          half_duplex_o,
  output logic [NUM_LINES-1:0]          auto_echo_lines_o
);
  import lcrb_pkg::*;

  lcrb_word_t           line_param_reg_q;
  logic [7:0]           active_lo_q;
  logic [7:0]           active_hi_q;
  lcrb_word_t           active_q;
  lcrb_word_t           break_ctl_reg_q;
  lcrb_word_t           line_cfg_q [NUM_LINES];
  lcrb_word_t           rd_data_d;
  lcrb_word_t           sel_cfg;
  logic [NUM_LINES-1:0] half_dup;
  logic [NUM_LINES-1:0] echo;

  // field pick-outs of one stored parameter word
  function automatic logic [5:0] fmt_field(input lcrb_word_t w);
    return w[`LCRB_FMT_MSB:`LCRB_FMT_LSB];
  endfunction : fmt_field

  function automatic logic [3:0] rx_rate_field(input lcrb_word_t w);
    return w[`LCRB_RXRATE_MSB:`LCRB_RXRATE_LSB];
  endfunction : rx_rate_field

  function automatic logic [3:0] tx_rate_field(input lcrb_word_t w);
    return w[`LCRB_TXRATE_MSB:`LCRB_TXRATE_LSB];
  endfunction : tx_rate_field

  function automatic logic half_dup_field(input lcrb_word_t w);
    return w[`LCRB_HALF_DUPLEX];
  endfunction : half_dup_field

  function automatic logic echo_field(input lcrb_word_t w);
    return w[`LCRB_AUTO_ECHO];
  endfunction : echo_field

  // parameter register as the host reads it back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_param_reg_q <= `LCRB_WORD_RST;
    end else if (param_load_strobe_i) begin
      line_param_reg_q <= host_data_buffered_i;
    end
  end

  // per-line copy taken for the selected line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        line_cfg_q[i] <= `LCRB_WORD_RST;
      end
    end else if (param_load_strobe_i) begin
      line_cfg_q[line_sel_i] <= host_data_buffered_i;
    end
  end

  // transmit-active register: two byte halves clocked by the one strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_lo_q <= 8'(`LCRB_WORD_RST);
    end else if (active_load_strobe_i) begin
      active_lo_q <= host_data_buffered_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_hi_q <= 8'(`LCRB_WORD_RST >> 8);
    end else if (active_load_strobe_i) begin
      active_hi_q <= host_data_buffered_i[15:8];
    end
  end

  always_comb begin
    active_q = {active_hi_q, active_lo_q};
  end

  // break control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      break_ctl_reg_q <= `LCRB_WORD_RST;
    end else if (brk_load_strobe_i) begin
      break_ctl_reg_q <= host_data_buffered_i;
    end
  end

  // read multiplexer, selected by address bits 1 to 3
  always_comb begin
    rd_data_d = `LCRB_WORD_RST;
    unique case (rd_addr_i)
      `LCRB_SRC_PARAM:  rd_data_d = line_param_reg_q;
      `LCRB_SRC_ACTIVE: rd_data_d = active_q;
      `LCRB_SRC_BRK:    rd_data_d = break_ctl_reg_q;
      default:          rd_data_d = `LCRB_WORD_RST;
    endcase
  end

  // read data holds between reads so the host sees a steady word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_o <= `LCRB_WORD_RST;
    end else if (rd_en_i) begin
      rd_data_o <= rd_data_d;
    end
  end

  // fields of the line chosen by the selection field
  always_comb begin
    sel_cfg = line_cfg_q[line_sel_i];
  end

  // character format of the selected line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      char_format_o <= 6'(`LCRB_WORD_RST);
    end else begin
      char_format_o <= fmt_field(sel_cfg);
    end
  end

  // receive rate of the selected line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_rate_o <= 4'(`LCRB_WORD_RST);
    end else begin
      rx_rate_o <= rx_rate_field(sel_cfg);
    end
  end

  // transmit rate of the selected line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_rate_o <= 4'(`LCRB_WORD_RST);
    end else begin
      tx_rate_o <= tx_rate_field(sel_cfg);
    end
  end

  // auto echo of the selected line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      auto_echo_o <= 1'(`LCRB_WORD_RST);
    end else begin
      auto_echo_o <= echo_field(sel_cfg);
    end
  end

  // per-line duplex and echo bits
  always_comb begin
    for (int i = 0; i < NUM_LINES; i++) begin
      half_dup[i] = half_dup_field(line_cfg_q[i]);
      echo[i]     = echo_field(line_cfg_q[i]);
    end
  end

  assign line_active_o = active_q[NUM_LINES-1:0];

  // one identical slice of routing per line
  for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
    lcrb_line_slice #(
      .IDLE_LEVEL (`LCRB_SERIAL_IDLE)
    ) u_slice (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .loop_i      (maintenance_loop_bit_i),
      .half_dup_i  (half_dup[g]),
      .echo_i      (echo[g]),
      .brk_i       (break_ctl_reg_q[g]),
      .char_done_i (tx_char_done_i[g]),
      .tx_serial_i (line_tx_serial_i[g]),
      .rx_pin_i    (line_rx_pin_i[g]),
      .rx_serial_o (line_rx_serial_o[g]),
      .tx_pin_o    (line_tx_pin_o[g]),
      .half_dup_o  (half_duplex_o[g]),
      .echo_o      (auto_echo_lines_o[g])
    );
  end

endmodule : lcrb_line_ctl

// one line's loopback, duplex blinding, break gating and registered pins
module lcrb_line_slice #(
  parameter logic IDLE_LEVEL = `LCRB_SERIAL_IDLE
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // line settings
  input  wire logic loop_i,
  input  wire logic half_dup_i,
  input  wire logic echo_i,
  input  wire logic brk_i,
  // serial data
  input  wire logic char_done_i,
  input  wire logic tx_serial_i,
  input  wire logic rx_pin_i,
  output logic      rx_serial_o,
  output logic      tx_pin_o,
  // registered settings
  output logic      half_dup_o,
  output logic      echo_o
);
  import lcrb_pkg::*;

  logic blind_n;
  logic restored;
  logic duplex_path;
  logic rx_serial_d;
  logic tx_pin_d;

  // low while a half-duplex transmitter is mid-character
  assign blind_n = !(half_dup_i && !char_done_i);

  // second inversion undoes the one made by the conversion panel
  assign restored    = ~rx_pin_i;
  assign duplex_path = blind_n ? restored : IDLE_LEVEL;

  assign rx_serial_d = loop_i ? tx_serial_i : duplex_path;

  // a set break bit holds the pin spacing
  assign tx_pin_d = tx_serial_i & ~brk_i;

  // receiver input is registered, one clock behind its sources
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_serial_o <= IDLE_LEVEL;
    end else begin
      rx_serial_o <= rx_serial_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_pin_o <= IDLE_LEVEL;
    end else begin
      tx_pin_o <= tx_pin_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      half_dup_o <= 1'(`LCRB_LINES_RST);
    end else begin
      half_dup_o <= half_dup_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      echo_o <= 1'(`LCRB_LINES_RST);
    end else begin
      echo_o <= echo_i;
    end
  end

endmodule : lcrb_line_slice

// ==== pkg/lcrb_defs.svh ====
// constants for the line control register bank
`ifndef LCRB_DEFS_SVH
`define LCRB_DEFS_SVH
`define LCRB_NUM_LINES     16
`define LCRB_WORD_W        16
`define LCRB_SRC_W         3
`define LCRB_SRC_PARAM     3'h2
`define LCRB_SRC_ACTIVE    3'h5
`define LCRB_SRC_BRK       3'h6
`define LCRB_FMT_LSB       0
`define LCRB_FMT_MSB       5
`define LCRB_RXRATE_LSB    6
`define LCRB_RXRATE_MSB    9
`define LCRB_TXRATE_LSB    10
`define LCRB_TXRATE_MSB    13
`define LCRB_HALF_DUPLEX   14
`define LCRB_AUTO_ECHO     15
`define LCRB_WORD_RST      16'h0000
`define LCRB_LINES_RST     16'h0000
`define LCRB_SERIAL_IDLE   1'b1
`endif

// ==== pkg/lcrb_pkg.sv ====
// types for the line control register bank
package lcrb_pkg;
  typedef logic [15:0] lcrb_word_t;
  typedef logic [3:0]  lcrb_line_t;
  typedef enum logic [2:0] {
    LCRB_SRC_PARAM  = 3'h2,
    LCRB_SRC_ACTIVE = 3'h5,
    LCRB_SRC_BRK    = 3'h6
  } lcrb_src_e;
endpackage : lcrb_pkg

// ==== testbench/lcrb_line_ctl_asserts.sv ====
// assertions on the line control register bank ports
`timescale 1ns/10ps
module lcrb_line_ctl_asserts #(
  parameter int NUM_LINES = 16
) (
  // watched ports
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire lcrb_pkg::lcrb_word_t host_data_buffered_i,
  input wire logic                 active_load_strobe_i,
  input wire logic                 brk_load_strobe_i,
  input wire logic                 rd_en_i,
  input wire logic [2:0]           rd_addr_i,
  input wire logic [15:0]          rd_data_o,
  input wire logic                 maintenance_loop_bit_i,
  input wire logic [NUM_LINES-1:0] line_active_o,
  input wire logic [NUM_LINES-1:0] line_tx_serial_i,
  input wire logic [NUM_LINES-1:0] tx_char_done_i,
  input wire logic [NUM_LINES-1:0] line_rx_pin_i,
  input wire logic [NUM_LINES-1:0] line_rx_serial_o,
  input wire logic [NUM_LINES-1:0] line_tx_pin_o
);
  import lcrb_pkg::*;
  // break bits as the host wrote them
  logic [NUM_LINES-1:0] brk_model;
  always_ff @(posedge clk_i) begin
    if (rst_i) brk_model <= '0;
    else if (brk_load_strobe_i) brk_model <= host_data_buffered_i[NUM_LINES-1:0];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  loop_path_a: assert property (maintenance_loop_bit_i |=>
    line_rx_serial_o == $past(line_tx_serial_i)) else $error("loopback path wrong");
  full_duplex_a: assert property (!maintenance_loop_bit_i && &tx_char_done_i |=>
    line_rx_serial_o == ~$past(line_rx_pin_i)) else $error("receive path wrong");
  break_gate_a: assert property (!$past(rst_i) |->
    line_tx_pin_o == ($past(line_tx_serial_i) & ~$past(brk_model)))
    else $error("tx pin not gated");
  active_load_a: assert property (active_load_strobe_i |=>
    line_active_o == $past(host_data_buffered_i)) else $error("active load wrong");
  active_hold_a: assert property (!active_load_strobe_i |=>
    $stable(line_active_o)) else $error("active changed unasked");
  read_hold_a: assert property (!rd_en_i |=>
    $stable(rd_data_o)) else $error("read data moved");
  unmapped_rd_a: assert property (rd_en_i && !(rd_addr_i inside {3'h2, 3'h5, 3'h6}) |=>
    rd_data_o == 16'h0000) else $error("unmapped read not zero");
  active_rd_a: assert property (rd_en_i && rd_addr_i == 3'h5 |=>
    rd_data_o == $past(line_active_o)) else $error("active read wrong");
endmodule : lcrb_line_ctl_asserts
bind lcrb_line_ctl lcrb_line_ctl_asserts #(.NUM_LINES(NUM_LINES)) u_chk (.clk_i, .rst_i,
  .host_data_buffered_i, .active_load_strobe_i, .brk_load_strobe_i, .rd_en_i, .rd_addr_i,
  .rd_data_o,
  .maintenance_loop_bit_i, .line_active_o, .line_tx_serial_i, .tx_char_done_i,
  .line_rx_pin_i, .line_rx_serial_o, .line_tx_pin_o);

// ==== testbench/lcrb_line_peer.sv ====
// far-side terminal model driving the incoming line pins
`timescale 1ns/10ps
module lcrb_line_peer (
  // terminal data and converted pins
  input  wire logic [15:0] data_i,
  output logic      [15:0] line_rx_pin_o
);
  // the conversion panel inverts what the terminal sends
  always_comb line_rx_pin_o = ~data_i;
endmodule : lcrb_line_peer

// ==== testbench/lcrb_line_ctl_tb.sv ====
// testbench for the line control register bank
`timescale 1ns/10ps
module lcrb_line_ctl_tb;
  import lcrb_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, rd_en_i = 1'b0, auto_echo_o;
  logic        param_load_strobe_i = 1'b0, active_load_strobe_i = 1'b0;
  logic        brk_load_strobe_i = 1'b0, maintenance_loop_bit_i = 1'b0;
  logic [2:0]  rd_addr_i = 3'h0;
  logic [3:0]  rx_rate_o, tx_rate_o;
  logic [5:0]  char_format_o;
  lcrb_word_t  host_data_buffered_i = 16'h0000, rd_data_o, peer_data = 16'h0000;
  lcrb_line_t  line_sel_i = 4'h3;
  logic [15:0] line_tx_serial_i = 16'hffff, tx_char_done_i = 16'hffff, line_rx_pin_i;
  logic [15:0] line_rx_serial_o, line_tx_pin_o, line_active_o;
  logic [15:0] half_duplex_o, auto_echo_lines_o;
  int          fail_count = 0, compares = 0;
  lcrb_line_ctl u_lcrb_line_ctl (
    .clk_i                  (clk_i),
    .rst_i                  (rst_i),
    .host_data_buffered_i   (host_data_buffered_i),
    .param_load_strobe_i    (param_load_strobe_i),
    .active_load_strobe_i   (active_load_strobe_i),
    .brk_load_strobe_i      (brk_load_strobe_i),
    .rd_en_i                (rd_en_i),
    .rd_addr_i              (rd_addr_i),
    .rd_data_o              (rd_data_o),
    .maintenance_loop_bit_i (maintenance_loop_bit_i),
    .line_sel_i             (line_sel_i),
    .char_format_o          (char_format_o),
    .rx_rate_o              (rx_rate_o),
    .tx_rate_o              (tx_rate_o),
    .auto_echo_o            (auto_echo_o),
    .line_active_o          (line_active_o),
    .line_tx_serial_i       (line_tx_serial_i),
    .tx_char_done_i         (tx_char_done_i),
    .line_rx_pin_i          (line_rx_pin_i),
    .line_rx_serial_o       (line_rx_serial_o),
    .line_tx_pin_o          (line_tx_pin_o),
    .half_duplex_o          (half_duplex_o),
    .auto_echo_lines_o      (auto_echo_lines_o)
  );
  lcrb_line_peer u_lcrb_line_peer (.data_i(peer_data), .line_rx_pin_o(line_rx_pin_i));
  initial forever #20 clk_i = ~clk_i;
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step
  task automatic close_out();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // which: 0 parameter, 1 transmit-active, 2 break
  task automatic wr(input int which, input logic [15:0] d);
    host_data_buffered_i = d;
    {param_load_strobe_i, active_load_strobe_i, brk_load_strobe_i} = 3'h4 >> which;
    step(1);
    {param_load_strobe_i, active_load_strobe_i, brk_load_strobe_i} = 3'h0;
    step(1);
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    rd_addr_i = a;
    rd_en_i = 1'b1;
    step(1);
    chk(rd_data_o, exp);
  endtask : rd
  initial begin
    step(5);
    rst_i = 1'b0;
    for (int a = 0; a < 8; a++) rd(a[2:0], 16'h0000);
    wr(0, 16'hd6a5);
    rd(3'h2, 16'hd6a5);
    chk({1'b0, rx_rate_o, tx_rate_o, auto_echo_o, char_format_o}, 16'h52e5);
    chk(half_duplex_o, 16'h0008);
    chk(auto_echo_lines_o, 16'h0008);
    line_sel_i = 4'h5;
    step(1);
    chk({1'b0, rx_rate_o, tx_rate_o, auto_echo_o, char_format_o}, 16'h0000);
    wr(1, 16'h5a3c);
    chk(line_active_o, 16'h5a3c);
    rd(3'h5, 16'h5a3c);
    wr(2, 16'h00ff);
    rd(3'h6, 16'h00ff);
    chk(line_tx_pin_o, 16'hff00);
    maintenance_loop_bit_i = 1'b1;
    line_tx_serial_i = 16'h1234;
    step(1);
    chk(line_rx_serial_o, 16'h1234);
    chk(line_tx_pin_o, 16'h1200);
    maintenance_loop_bit_i = 1'b0;
    peer_data = 16'hbeef;
    step(1);
    chk(line_rx_serial_o, 16'hbeef);
    peer_data = 16'h0000;
    tx_char_done_i = 16'hfff6;
    rd_en_i = 1'b0;
    step(1);
    chk(line_rx_serial_o, 16'h0008);
    rst_i = 1'b1;
    step(1);
    rst_i = 1'b0;
    chk(half_duplex_o, 16'h0000);
    rd(3'h2, 16'h0000);
    rd(3'h5, 16'h0000);
    rd(3'h6, 16'h0000);
    step(2);
    close_out();
  end
  initial begin
    repeat (1000) @(posedge clk_i);
    fail_count++;
    close_out();
  end
endmodule : lcrb_line_ctl_tb
